// ===== src/ssau_cfg.svh
`ifndef SSAU_CFG_SVH
`define SSAU_CFG_SVH
// operation codes presented on op_in
`define SSAU_OP_NONE      4'h0
`define SSAU_OP_S_ASX     4'h1
`define SSAU_OP_S_SAX     4'h2
`define SSAU_OP_S_DADD    4'h3
`define SSAU_OP_S_DSUB    4'h4
`define SSAU_OP_U_ASX     4'h5
`define SSAU_OP_U_SAX     4'h6
`define SSAU_OP_U_HADD    4'h7
`define SSAU_OP_U_BADD    4'h8
`define SSAU_OP_U_HSUB    4'h9
`define SSAU_OP_U_BSUB    4'hA
// register index of the two excluded registers
`define SSAU_REG_SP       4'hD
`define SSAU_REG_PC       4'hF
// reset values
`define SSAU_RST_RESULT   32'h0000_0000
`define SSAU_RST_FLAG     1'b0
`define SSAU_RST_DEST     4'h0
`define SSAU_RST_NZCV     4'h0
`endif

// ===== src/ssau_pkg.sv
package ssau_pkg;
   typedef logic [3:0]  ssau_op_t;
   typedef logic [31:0] ssau_word_t;
   typedef logic [3:0]  ssau_reg_t;
endpackage

// ===== src/ssau_lane_if.sv
`timescale 1ns/1ps
// operands into the lane block and packed results back
interface ssau_lane_if;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] half_add;
   logic [31:0] half_sub;
   logic [31:0] byte_add;
   logic [31:0] byte_sub;
   modport core
   (
      output a,
      output b,
      input  half_add,
      input  half_sub,
      input  byte_add,
      input  byte_sub
   );
   modport lanes
   (
      input  a,
      input  b,
      output half_add,
      output half_sub,
      output byte_add,
      output byte_sub
   );
endinterface

// ===== src/ssau_lanes.sv
`timescale 1ns/1ps
// unsigned saturating lanes, straight halfwords and bytes
module ssau_lanes
   import ssau_pkg::*;
(
   ssau_lane_if.lanes lif
);
   // a 17-bit / 9-bit result keeps each lane's carry to itself
   function automatic logic [15:0] uadd16(input logic [15:0] x,
                                          input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} + {1'b0, y};
      uadd16 = s[16] ? 16'hFFFF : s[15:0];
   endfunction

   function automatic logic [15:0] usub16(input logic [15:0] x,
                                          input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} - {1'b0, y};
      usub16 = s[16] ? 16'h0000 : s[15:0];
   endfunction

   function automatic logic [7:0] uadd8(input logic [7:0] x,
                                        input logic [7:0] y);
      logic [8:0] s;
      s = {1'b0, x} + {1'b0, y};
      uadd8 = s[8] ? 8'hFF : s[7:0];
   endfunction

   function automatic logic [7:0] usub8(input logic [7:0] x,
                                        input logic [7:0] y);
      logic [8:0] s;
      s = {1'b0, x} - {1'b0, y};
      usub8 = s[8] ? 8'h00 : s[7:0];
   endfunction

   assign lif.half_add = {uadd16(lif.a[31:16], lif.b[31:16]),
                          uadd16(lif.a[15:0], lif.b[15:0])};
   assign lif.half_sub = {usub16(lif.a[31:16], lif.b[31:16]),
                          usub16(lif.a[15:0], lif.b[15:0])};

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_byte
         assign lif.byte_add[8*i+7:8*i] = uadd8(lif.a[8*i+7:8*i],
                                                lif.b[8*i+7:8*i]);
         assign lif.byte_sub[8*i+7:8*i] = usub8(lif.a[8*i+7:8*i],
                                                lif.b[8*i+7:8*i]);
      end
   endgenerate
endmodule

// ===== src/ssau_top.sv
`timescale 1ns/1ps
`include "ssau_cfg.svh"
// What this block does
// - signed add-sub exchange: hi(a)+lo(b) saturated into result high
// - signed add-sub exchange: lo(a)-hi(b) saturated into result low
// - signed sub-add exchange: lo(a)+hi(b) saturated into result low
// - signed sub-add exchange: hi(a)-lo(b) saturated into result high
// - exchange operations leave N, Z, C and V flags untouched
// - double-add: saturate 2*b, add to a, saturate to 32 bits
// - double-sub: saturate 2*b, subtract from a, saturate to 32 bits
// - doubling and add/sub steps each saturate independently
// - saturation in either double step sets sticky flag
// - unsigned add-sub exchange: clamped sum into result high
// - unsigned add-sub exchange: clamped difference into result low
// - unsigned sub-add exchange: difference high, sum low, clamped
// - unsigned halfword add clamps each lane to 16 bits
// - unsigned byte add clamps each lane to 0..255
// - unsigned halfword subtract clamps each lane to 16 bits
// - unsigned byte subtract clamps each lane, underflow gives zero
// - sticky flag only cleared by explicit status write
module ssau_top
   import ssau_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic       issue_in,
   input  wire ssau_op_t   op_in,
   input  wire ssau_word_t opnd_a_in,
   input  wire ssau_word_t opnd_b_in,
   input  wire ssau_reg_t  dest_in,
   input  wire logic       flag_wr_in,
   input  wire logic       flag_wr_val_in,
   input  wire logic [3:0] nzcv_in,
   output logic            valid_out,
   output ssau_word_t      result_out,
   output ssau_reg_t       dest_out,
   output logic            sat_out,
   output logic            sticky_sat_out,
   output logic [3:0]      nzcv_out,
   output logic            bad_reg_out
);
   ////////////////////////////////////////////////////////////////////
   // registers
   logic       valid_q;
   ssau_word_t result_q;
   ssau_word_t result_d;
   ssau_reg_t  dest_q;
   logic       sat_q;
   logic       sat_d;
   logic       sticky_q;
   logic       sticky_d;
   logic [3:0] nzcv_q;
   logic       bad_q;
   logic       bad_d;

   ssau_lane_if lif ();

   assign lif.a = opnd_a_in;
   assign lif.b = opnd_b_in;

   ssau_lanes u_lanes
   (
      .lif (lif)
   );

   ////////////////////////////////////////////////////////////////////
   // arithmetic helpers
   // signed 16-bit clamp of a 17-bit signed value
   function automatic logic [15:0] ssat16(input logic [16:0] v);
      if (v[16] != v[15])
         ssat16 = v[16] ? 16'h8000 : 16'h7FFF;
      else
         ssat16 = v[15:0];
   endfunction

   // signed 32-bit clamp of a 33-bit signed value
   function automatic logic [31:0] ssat32(input logic [32:0] v);
      if (v[32] != v[31])
         ssat32 = v[32] ? 32'h8000_0000 : 32'h7FFF_FFFF;
      else
         ssat32 = v[31:0];
   endfunction

   // overflow of a 33-bit signed value: its two top bits disagree
   function automatic logic ovf(input logic [32:0] v);
      ovf = v[32] ^ v[31];
   endfunction

   // one extra sign bit, so a halfword sum or difference cannot wrap
   function automatic logic [16:0] sx16(input logic [15:0] v);
      sx16 = {v[15], v};
   endfunction

   // register indices that the issuer must never name
   function automatic logic is_excluded_reg(input ssau_reg_t r);
      is_excluded_reg = (r == `SSAU_REG_SP) || (r == `SSAU_REG_PC);
   endfunction

   // unsigned clamps for the exchange ops; the straight lanes keep
   // their own copies inside the lane block
   function automatic logic [15:0] uadd16(input logic [15:0] x,
                                          input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} + {1'b0, y};
      uadd16 = s[16] ? 16'hFFFF : s[15:0];
   endfunction

   function automatic logic [15:0] usub16(input logic [15:0] x,
                                          input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} - {1'b0, y};
      usub16 = s[16] ? 16'h0000 : s[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // exchange lane sums, each 17 bits so lanes never interact
   logic [16:0] hi_a_lo_b_add;
   logic [16:0] lo_a_hi_b_sub;
   logic [16:0] lo_a_hi_b_add;
   logic [16:0] hi_a_lo_b_sub;

   // every pair is worked out whatever the op and the case below only
   // picks one; cheaper than sharing adders behind an operand mux
   // separate lane arithmetic
   assign hi_a_lo_b_add = sx16(opnd_a_in[31:16]) + sx16(opnd_b_in[15:0]);
   assign lo_a_hi_b_sub = sx16(opnd_a_in[15:0]) - sx16(opnd_b_in[31:16]);
   assign lo_a_hi_b_add = sx16(opnd_a_in[15:0]) + sx16(opnd_b_in[31:16]);
   assign hi_a_lo_b_sub = sx16(opnd_a_in[31:16]) - sx16(opnd_b_in[15:0]);

   // doubling step and final step of the 32-bit double operations
   logic [32:0] dbl_raw;
   logic [31:0] dbl_sat;
   logic [32:0] dadd_raw;
   logic [32:0] dsub_raw;

   // the doubled operand is clamped before the add, so a sum that
   // falls back into range still reports the doubling overflow
   // doubling saturates alone
   assign dbl_raw  = {opnd_b_in, 1'b0};
   assign dbl_sat  = ssat32(dbl_raw);
   assign dadd_raw = {opnd_a_in[31], opnd_a_in} + {dbl_sat[31], dbl_sat};
   assign dsub_raw = {opnd_a_in[31], opnd_a_in} - {dbl_sat[31], dbl_sat};

   ////////////////////////////////////////////////////////////////////
   // result select; only double ops can raise saturation
   always_comb
   begin
      result_d = 32'h0000_0000;
      sat_d    = 1'b0;
      case (op_in)
         `SSAU_OP_S_ASX:
         begin
            result_d = {ssat16(hi_a_lo_b_add), ssat16(lo_a_hi_b_sub)};
         end
         `SSAU_OP_S_SAX:
         begin
            result_d = {ssat16(hi_a_lo_b_sub), ssat16(lo_a_hi_b_add)};
         end
         `SSAU_OP_S_DADD:
         begin
            result_d = ssat32(dadd_raw);
            sat_d    = ovf(dbl_raw) | ovf(dadd_raw);
         end
         `SSAU_OP_S_DSUB:
         begin
            result_d = ssat32(dsub_raw);
            sat_d    = ovf(dbl_raw) | ovf(dsub_raw);
         end
         `SSAU_OP_U_ASX:
         begin
            result_d = {uadd16(opnd_a_in[31:16], opnd_b_in[15:0]),
                        usub16(opnd_a_in[15:0], opnd_b_in[31:16])};
         end
         `SSAU_OP_U_SAX:
         begin
            result_d = {usub16(opnd_a_in[31:16], opnd_b_in[15:0]),
                        uadd16(opnd_a_in[15:0], opnd_b_in[31:16])};
         end
         `SSAU_OP_U_HADD: result_d = lif.half_add;
         `SSAU_OP_U_BADD: result_d = lif.byte_add;
         `SSAU_OP_U_HSUB: result_d = lif.half_sub;
         `SSAU_OP_U_BSUB: result_d = lif.byte_sub;
         default:
         begin
            // unknown codes give zero and never touch the flag
            result_d = 32'h0000_0000;
            sat_d    = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // valid is a one-cycle pulse, one edge after acceptance
   // valid pulse
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         valid_q <= 1'b0;
      else
         valid_q <= issue_in;
   end

   // result holds until the next accepted op, so a late reader of
   // the write-back side still sees the last value
   // result hold
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         result_q <= `SSAU_RST_RESULT;
      else if (issue_in)
         result_q <= result_d;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         dest_q <= `SSAU_RST_DEST;
      else if (issue_in)
         dest_q <= dest_in;
   end

   // per-op saturation lands in the same cycle as the result; it is
   // a pulse, the sticky copy below keeps the history
   // saturation pulse
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         sat_q <= `SSAU_RST_FLAG;
      else
         sat_q <= issue_in && sat_d;
   end

   ////////////////////////////////////////////////////////////////////
   // the set is applied last: an op that saturates outranks a status
   // write in the same cycle, so no overflow is lost to a racing clear
   // sticky next value
   always_comb
   begin
      sticky_d = sticky_q;
      if (flag_wr_in)
         sticky_d = flag_wr_val_in;
      if (issue_in && sat_d)
         sticky_d = 1'b1;
   end

   // no operation ever clears the flag, only a status write does
   // sticky register
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         sticky_q <= `SSAU_RST_FLAG;
      else
         sticky_q <= sticky_d;
   end

   ////////////////////////////////////////////////////////////////////
   // none of these ops works out N, Z, C or V, so the copy has no
   // path that could alter them; it only lines up with the result
   // flags pass through
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         nzcv_q <= `SSAU_RST_NZCV;
      else
         nzcv_q <= nzcv_in;
   end

   ////////////////////////////////////////////////////////////////////
   // the block cannot refuse an op, so a breach is only reported, as
   // a one-cycle pulse beside the result it spoils
   // breach detect
   always_comb
   begin
      bad_d = 1'b0;
      if (issue_in)
         bad_d = is_excluded_reg(dest_in);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
         bad_q <= 1'b0;
      else
         bad_q <= bad_d;
   end

   ////////////////////////////////////////////////////////////////////
   // every output comes straight from a register
   assign valid_out      = valid_q;
   assign result_out     = result_q;
   assign dest_out       = dest_q;
   assign sat_out        = sat_q;
   assign sticky_sat_out = sticky_q;
   assign nzcv_out       = nzcv_q;
   assign bad_reg_out    = bad_q;
endmodule

// ===== test/ssau_top_sva.sv
`timescale 1ns/1ps
`include "ssau_cfg.svh"
// port-level checks of the saturating unit
module ssau_top_sva
   import ssau_pkg::*;
(
   input wire logic       clk_sys_in,
   input wire logic       sys_rst_in,
   input wire logic       issue_in,
   input wire ssau_op_t   op_in,
   input wire ssau_word_t opnd_a_in,
   input wire ssau_word_t opnd_b_in,
   input wire ssau_reg_t  dest_in,
   input wire logic       flag_wr_in,
   input wire logic       flag_wr_val_in,
   input wire logic [3:0] nzcv_in,
   input wire logic       valid_out,
   input wire ssau_word_t result_out,
   input wire ssau_reg_t  dest_out,
   input wire logic       sat_out,
   input wire logic       sticky_sat_out,
   input wire logic [3:0] nzcv_out,
   input wire logic       bad_reg_out
);
   // lowest byte lane widened so its carry and borrow are visible
   logic [8:0] lo_sum;
   logic [8:0] lo_dif;
   assign lo_sum = {1'b0, opnd_a_in[7:0]} + {1'b0, opnd_b_in[7:0]};
   assign lo_dif = {1'b0, opnd_a_in[7:0]} - {1'b0, opnd_b_in[7:0]};
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////
   // answer next cycle
   property p_answer; issue_in |=> valid_out && dest_out == $past(dest_in);
   endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   property p_quiet; !issue_in |=> !valid_out && $stable(result_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("spurious output");
   property p_flags; issue_in |=> nzcv_out == $past(nzcv_in);
   endproperty
   a_flags: assert property (p_flags) else $error("flags altered");
   property p_keep; sticky_sat_out && !flag_wr_in |=> sticky_sat_out;
   endproperty
   a_keep: assert property (p_keep) else $error("sticky dropped");
   property p_stick; sat_out |-> sticky_sat_out && valid_out;
   endproperty
   a_stick: assert property (p_stick) else $error("sticky not set");
   property p_nosat;
      issue_in && !(op_in inside {`SSAU_OP_S_DADD, `SSAU_OP_S_DSUB})
      |=> !sat_out;
   endproperty
   a_nosat: assert property (p_nosat) else $error("flag touched");
   property p_badd; issue_in && op_in == `SSAU_OP_U_BADD |=>
      result_out[7:0] == ($past(lo_sum[8]) ? 8'hFF : $past(lo_sum[7:0]));
   endproperty
   a_badd: assert property (p_badd) else $error("byte add wrong");
   property p_bsub; issue_in && op_in == `SSAU_OP_U_BSUB |=>
      result_out[7:0] == ($past(lo_dif[8]) ? 8'h00 : $past(lo_dif[7:0]));
   endproperty
   a_bsub: assert property (p_bsub) else $error("byte sub wrong");
   // a status write of one sets sticky
   property p_wr1; flag_wr_in && flag_wr_val_in |=> sticky_sat_out;
   endproperty
   a_wr1: assert property (p_wr1) else $error("sticky not written");
   // breach flag mirrors the named destination
   property p_bad; issue_in |=>
      bad_reg_out == $past(dest_in inside {`SSAU_REG_SP, `SSAU_REG_PC});
   endproperty
   a_bad: assert property (p_bad) else $error("breach flag wrong");
   c_sat: cover property (valid_out && sat_out);
   c_b2b: cover property (issue_in ##1 issue_in);
   c_clr: cover property ($fell(sticky_sat_out));
endmodule

// ===== test/ssau_core_model.sv
`timescale 1ns/1ps
`include "ssau_cfg.svh"
// issue side of the core: op, operands, destination, flags
module ssau_core_model
   import ssau_pkg::*;
(
   input  wire logic  clk_sys_in,
   output logic       issue_out = 1'b0,
   output ssau_op_t   op_out = 4'h0,
   output ssau_word_t a_out = 32'h0000_0000,
   output ssau_word_t b_out = 32'h0000_0000,
   output ssau_reg_t  dest_out = 4'h0,
   output logic [3:0] nzcv_out = 4'h0
);
   // one request per edge; destination index mirrors the op code, except that the SP and PC codes give index 0
   task automatic issue(input ssau_op_t o, input ssau_word_t x, y);
      @(posedge clk_sys_in);
      issue_out <= 1'b1;
      op_out <= o;
      a_out <= x;
      b_out <= y;
      nzcv_out <= x[31:28]; // varied so a stuck copy shows
      dest_out <= (o == `SSAU_REG_SP || o == `SSAU_REG_PC) ? 4'h0 : o;
   endtask
   // release; operands turn over so stale values cannot pass
   task automatic idle();
      @(posedge clk_sys_in);
      issue_out <= 1'b0;
      a_out <= ~a_out;
      b_out <= ~b_out;
   endtask
endmodule

// ===== test/ssau_top_bench.sv
`timescale 1ns/1ps
`include "ssau_cfg.svh"
// self-checking bench for the saturating unit
module ssau_top_bench
   import ssau_pkg::*;
;
   localparam longint MX = 64'sh0000_0000_7FFF_FFFF;
   logic       clk_sys_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       flag_wr_in = 1'b0;
   logic       flag_wr_val_in = 1'b0;
   logic       issue_in, valid_out, sat_out, sticky_sat_out, bad_reg_out;
   ssau_op_t   op_in;
   ssau_word_t opnd_a_in, opnd_b_in, result_out;
   ssau_reg_t  dest_in, dest_out;
   logic [3:0] nzcv_in, nzcv_out;
   logic       stk = 1'b0;
   int         errors = 0;
   int         comparisons = 0;
   // 100 MHz clock
   always #5 clk_sys_in = ~clk_sys_in;
   ssau_core_model core (.clk_sys_in, .issue_out(issue_in), .op_out(op_in),
      .a_out(opnd_a_in), .b_out(opnd_b_in), .dest_out(dest_in),
      .nzcv_out(nzcv_in));
   ssau_top DUT (.clk_sys_in, .sys_rst_in, .issue_in, .op_in, .opnd_a_in,
      .opnd_b_in, .dest_in, .flag_wr_in, .flag_wr_val_in, .nzcv_in,
      .valid_out, .result_out, .dest_out, .sat_out, .sticky_sat_out,
      .nzcv_out, .bad_reg_out);
   ////////////////////////////////////////
   // reference clamps; wide ints so no intermediate wraps
   function automatic logic [15:0] cl(input longint v, lo, hi);
      return v < lo ? lo[15:0] : (v > hi ? hi[15:0] : v[15:0]);
   endfunction
   function automatic longint c32(input longint v);
      return v > MX ? MX : (v < -MX - 1 ? -MX - 1 : v);
   endfunction
   function automatic longint hf(input ssau_word_t v, input int i, sg);
      return sg ? longint'($signed(v[16*i+:16])) : longint'(v[16*i+:16]);
   endfunction
   function automatic logic [32:0] ref_op(input ssau_op_t o,
                                          input ssau_word_t x, y);
      logic [32:0] r;
      longint      d, s, u, v, n, m;
      int          w, sg;
      r = '0;
      sg = o <= `SSAU_OP_S_SAX;
      n = sg ? -32768 : 0;
      m = sg ? 32767 : 65535;
      if (o == `SSAU_OP_S_ASX || o == `SSAU_OP_U_ASX)
         r[31:0] = {cl(hf(x, 1, sg) + hf(y, 0, sg), n, m),
                    cl(hf(x, 0, sg) - hf(y, 1, sg), n, m)};
      else if (o == `SSAU_OP_S_SAX || o == `SSAU_OP_U_SAX)
         r[31:0] = {cl(hf(x, 1, sg) - hf(y, 0, sg), n, m),
                    cl(hf(x, 0, sg) + hf(y, 1, sg), n, m)};
      else if (o == `SSAU_OP_S_DADD || o == `SSAU_OP_S_DSUB)
      begin
         d = 2 * longint'($signed(y));
         u = longint'($signed(x));
         s = o == `SSAU_OP_S_DADD ? u + c32(d) : u - c32(d);
         r[32] = c32(d) != d || c32(s) != s;
         r[31:0] = 32'(c32(s));
      end
      else if (o >= `SSAU_OP_U_HADD && o <= `SSAU_OP_U_BSUB)
      begin
         w = (o == `SSAU_OP_U_HADD || o == `SSAU_OP_U_HSUB) ? 16 : 8;
         m = (64'h1 << w) - 1;
         for (int i = 0; i < 32 / w; i++)
         begin
            u = longint'((x >> w * i) & m);
            v = longint'((y >> w * i) & m);
            s = o >= `SSAU_OP_U_HSUB ? u - v : u + v;
            r[31:0] |= 32'(cl(s, 0, m)) << w * i;
         end
      end
      return r;
   endfunction
   task automatic chk(input logic [43:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // judge one operation the edge after capture
   task automatic verify(input ssau_op_t o, input ssau_word_t x, y);
      logic [32:0] e;
      e = ref_op(o, x, y);
      stk = stk | e[32];
      chk({valid_out, sat_out, sticky_sat_out, dest_out,
           nzcv_out, bad_reg_out, result_out},
          {1'b1, e[32], stk, o, x[31:28], 1'b0, e[31:0]});
   endtask
   task automatic run(input ssau_op_t o, input ssau_word_t x, y);
      core.issue(o, x, y);
      core.idle();
      #1;
      verify(o, x, y);
   endtask
   ////////////////////////////////////////
   task automatic t_exch();
      for (ssau_op_t o = 4'h1; o <= 4'h6; o++)
      begin
         if (o == `SSAU_OP_S_DADD || o == `SSAU_OP_S_DSUB)
            continue;
         run(o, 32'h7FFF_8000, 32'h0001_0001);
         run(o, 32'hFFFF_0000, 32'h0002_0001);
      end
      $display("exchange test done");
   endtask
   task automatic t_dbl();
      for (ssau_op_t o = `SSAU_OP_S_DADD; o <= `SSAU_OP_S_DSUB; o++)
      begin
         run(o, 32'h0000_0001, 32'h0000_0002);
         run(o, 32'h0000_0000, 32'h4000_0000);
         run(o, 32'h7FFF_FFF0, 32'h0000_0010);
         run(o, 32'h8000_0010, 32'h0000_0010);
      end
      $display("double test done");
   endtask
   task automatic t_pack();
      for (ssau_op_t o = `SSAU_OP_U_HADD; o <= `SSAU_OP_U_BSUB; o++)
      begin
         run(o, 32'hFF80_7FFF, 32'h0081_0001);
         run(o, 32'h0100_00FF, 32'h0001_0001);
      end
      $display("packed test done");
   endtask
   // clear racing a saturating op, then a lone clear and a lone set
   task automatic t_flag();
      stk = 1'b0;
      core.issue(`SSAU_OP_S_DADD, 32'h7FFF_FFFF, 32'h0000_0001);
      flag_wr_in <= 1'b1;
      core.idle();
      flag_wr_in <= 1'b0;
      #1;
      verify(`SSAU_OP_S_DADD, 32'h7FFF_FFFF, 32'h0000_0001);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_sys_in);
         flag_wr_in     <= 1'b1;
         flag_wr_val_in <= v[0];
         @(posedge clk_sys_in);
         flag_wr_in <= 1'b0;
         #1;
         stk = v[0];
         chk(44'(sticky_sat_out), 44'(stk));
      end
      $display("status write test done");
   endtask
   // unknown op then byte add on consecutive edges
   task automatic t_b2b();
      core.issue(4'hB, 32'h1234_5678, 32'h1111_1111);
      core.issue(`SSAU_OP_U_BADD, 32'hF0F0_F0F0, 32'h2020_2020);
      #1;
      verify(4'hB, 32'h1234_5678, 32'h1111_1111);
      core.idle();
      #1;
      verify(`SSAU_OP_U_BADD, 32'hF0F0_F0F0, 32'h2020_2020);
      $display("back to back test done");
   endtask
   task automatic wrap_up();
      $display("%0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      t_exch();
      t_dbl();
      t_pack();
      t_flag();
      t_b2b();
      wrap_up();
   end
   // watchdog; the tests need about 60 cycles
   initial
   begin
      repeat (2000) @(posedge clk_sys_in);
      errors++;
      $display("mismatch at %0t: run hung", $time);
      wrap_up();
   end
endmodule
bind ssau_top ssau_top_sva u_sva (.clk_sys_in, .sys_rst_in, .issue_in,
   .op_in, .opnd_a_in, .opnd_b_in, .dest_in, .flag_wr_in, .flag_wr_val_in,
   .nzcv_in, .valid_out, .result_out, .dest_out, .sat_out, .sticky_sat_out,
   .nzcv_out, .bad_reg_out);
